// ### shared/tw_port_consts.vh
// register map, field positions, status codes and timing defaults of the two-wire port
`ifndef TW_PORT_CONSTS_VH
`define TW_PORT_CONSTS_VH
`define TW_OFF_OWN 8'h00
`define TW_OFF_CTL 8'h04
`define TW_OFF_DAT 8'h08
`define TW_OFF_STA 8'h0c
`define TW_OFF_SEL 8'h10
`define TW_OFF_IE 8'h14
`define TW_OFF_EVT 8'h18
`define TW_BC_CR2 7
`define TW_BC_BYTE_ENGINE_ENABLE 6
`define TW_BC_STA 5
`define TW_BC_STO 4
`define TW_BC_SI 3
`define TW_BC_AA 2
`define TW_BS_SDA 7
`define TW_BS_SCL 6
`define TW_BS_CLH 5
`define TW_BS_BB 4
`define TW_BS_RBF 3
`define TW_BS_WBF 2
`define TW_BS_STR 1
`define TW_BS_ENS 0
`define TW_IE_MASTER 7
`define TW_IE_BIT 1
`define TW_IE_BYTE 0
`define TW_QUARTER_BASE 13'h0020
`define TW_ST_IDLE 5'h1f
`define TW_ST_START 5'h01
`define TW_ST_RSTART 5'h02
`define TW_ST_MT_AACK 5'h03
`define TW_ST_MT_ANACK 5'h04
`define TW_ST_MT_DACK 5'h05
`define TW_ST_MT_DNACK 5'h06
`define TW_ST_ARB 5'h07
`define TW_ST_MR_AACK 5'h08
`define TW_ST_MR_ANACK 5'h09
`define TW_ST_MR_DACK 5'h0a
`define TW_ST_MR_DNACK 5'h0b
`define TW_ST_SR_AACK 5'h0c
`define TW_ST_SR_GACK 5'h0e
`define TW_ST_SR_DACK 5'h10
`define TW_ST_SR_DNACK 5'h11
`define TW_ST_SR_STOP 5'h14
`define TW_ST_ST_AACK 5'h15
`define TW_ST_ST_DACK 5'h17
`define TW_ST_ST_DNACK 5'h18
`endif

// ### hdl/tw_port.v
// dual-level two-wire serial port with apb register access
`include "tw_port_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module tw_port #(
	parameter [12:0] QUARTER_BASE = `TW_QUARTER_BASE
)(
	input wire ref_clk,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire sda_i,
	output reg sda_o,
	output reg sda_oe_n,
	input wire scl_i,
	output reg scl_o,
	output reg scl_oe_n,
	output reg irq
);
	localparam S_IDLE = 3'd0;
	localparam S_MSTART = 3'd1;
	localparam S_MBIT = 3'd2;
	localparam S_WAIT = 3'd3;
	localparam S_MSTOP = 3'd4;
	localparam S_SBIT = 3'd5;

	// pin synchronisers; the extra stage gives a clean previous value for edges
	reg [1:0] sda_sync_r;
	reg [1:0] scl_sync_r;
	reg sda_q_r;
	reg scl_q_r;
	wire sda_s = sda_sync_r[1];
	wire scl_s = scl_sync_r[1];
	wire bus_start = scl_s & sda_q_r & ~sda_s;
	wire bus_stop = scl_s & ~sda_q_r & sda_s;
	wire scl_rise = scl_s & ~scl_q_r;
	wire scl_fall = ~scl_s & scl_q_r;

	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			sda_sync_r <= 2'h3;
			scl_sync_r <= 2'h3;
			sda_q_r <= 1'b1;
			scl_q_r <= 1'b1;
		end
		else
		begin
			sda_sync_r <= {sda_sync_r[0], sda_i};
			scl_sync_r <= {scl_sync_r[0], scl_i};
			sda_q_r <= sda_s;
			scl_q_r <= scl_s;
		end
	end

	// apb: one wait state, writes and read side effects land on the completing edge
	wire acc = psel & penable;
	wire done = acc & pready;
	wire wr_en = done & pwrite;
	wire rd_en = done & ~pwrite;
	wire [7:0] wb = pwdata[7:0];
	reg sel_r;
	wire wr_own = wr_en & (paddr == `TW_OFF_OWN);
	wire wr_bctl = wr_en & sel_r & (paddr == `TW_OFF_CTL);
	wire wr_bdat = wr_en & sel_r & (paddr == `TW_OFF_DAT);
	wire wr_scs = wr_en & ~sel_r & (paddr == `TW_OFF_CTL);
	wire wr_sbd = wr_en & ~sel_r & (paddr == `TW_OFF_DAT);
	wire rd_sbd = rd_en & ~sel_r & (paddr == `TW_OFF_DAT);
	wire wr_sint = wr_en & ~sel_r & (paddr == `TW_OFF_STA);

	// byte engine state
	reg [7:0] own_addr_r;
	reg [2:0] cr_r;
	reg byte_engine_enable_r;
	reg sta_r;
	reg sto_r;
	reg si_r;
	reg aa_r;
	reg [7:0] shift_r;
	reg [4:0] stat_r;
	reg [2:0] bst_r;
	reg master_r;
	reg rs_r;
	reg tx_r;
	reg adr_ph_r;
	reg ack_r;
	reg [3:0] bcnt_r;
	reg [1:0] ph_r;
	reg [12:0] qcnt_r;
	reg bsda_r;
	reg bscl_r;
	// bit engine state
	reg sdo_r;
	reg sco_r;
	reg clh_r;
	reg str_r;
	reg ens_r;
	reg bb_r;
	reg rbf_r;
	reg wbf_r;
	reg bsi_r;
	reg wr_pend_r;

	// wider rate codes divide further; the shift stays inside thirteen bits by default
	wire [12:0] qlen = QUARTER_BASE << cr_r;
	wire stall = (ph_r == 2'h2) & ~scl_s;
	wire tick = (qcnt_r == qlen - 13'h0001) & ~stall;
	wire txing = adr_ph_r | tx_r;
	wire own_hit = (shift_r[7:1] == own_addr_r[7:1]);
	wire gc_hit = own_addr_r[0] & (shift_r == 8'h00);

	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			cr_r <= 3'h0;
			byte_engine_enable_r <= 1'b0;
			sta_r <= 1'b0;
			sto_r <= 1'b0;
			si_r <= 1'b0;
			aa_r <= 1'b0;
			shift_r <= 8'h00;
			stat_r <= `TW_ST_IDLE;
			bst_r <= S_IDLE;
			master_r <= 1'b0;
			rs_r <= 1'b0;
			tx_r <= 1'b0;
			adr_ph_r <= 1'b0;
			ack_r <= 1'b0;
			bcnt_r <= 4'h0;
			ph_r <= 2'h0;
			qcnt_r <= 13'h0;
			bsda_r <= 1'b0;
			bscl_r <= 1'b0;
		end
		else
		begin
			if (wr_bctl)
			begin
				cr_r <= {wb[`TW_BC_CR2], wb[1:0]};
				byte_engine_enable_r <= wb[`TW_BC_BYTE_ENGINE_ENABLE];
				sta_r <= wb[`TW_BC_STA];
				sto_r <= wb[`TW_BC_STO];
				aa_r <= wb[`TW_BC_AA];
				if (!wb[`TW_BC_SI])
					si_r <= 1'b0;
			end
			if (wr_bdat)
				shift_r <= wb;
			qcnt_r <= (tick | stall) ? 13'h0 : qcnt_r + 13'h0001;
			if (!byte_engine_enable_r)
			begin
				bst_r <= S_IDLE;
				bsda_r <= 1'b0;
				bscl_r <= 1'b0;
				master_r <= 1'b0;
			end
			else
			begin
				case (bst_r)
					S_IDLE:
					begin
						bsda_r <= 1'b0;
						bscl_r <= 1'b0;
						qcnt_r <= 13'h0;
						ph_r <= 2'h0;
						if (sta_r & ~bb_r)
						begin
							bst_r <= S_MSTART;
							master_r <= 1'b1;
							rs_r <= 1'b0;
						end
						else if (bus_start)
						begin
							bst_r <= S_SBIT;
							master_r <= 1'b0;
							adr_ph_r <= 1'b1;
							tx_r <= 1'b0;
							bcnt_r <= 4'h0;
						end
					end
					S_MSTART:
						if (tick)
						begin
							ph_r <= ph_r + 2'h1;
							case (ph_r)
								2'h0: bsda_r <= 1'b0;
								2'h1: bscl_r <= 1'b0;
								2'h2: bsda_r <= 1'b1;
								default:
								begin
									bscl_r <= 1'b1;
									si_r <= 1'b1;
									stat_r <= rs_r ? `TW_ST_RSTART : `TW_ST_START;
									adr_ph_r <= 1'b1;
									bst_r <= S_WAIT;
								end
							endcase
						end
					S_MBIT:
						if (tick)
						begin
							ph_r <= ph_r + 2'h1;
							case (ph_r)
								2'h0:
									if (bcnt_r == 4'h8)
										bsda_r <= ~txing & aa_r;
									else
										bsda_r <= txing & ~shift_r[7];
								2'h1: bscl_r <= 1'b0;
								2'h2:
									if (bcnt_r == 4'h8)
										ack_r <= ~sda_s;
									else if (txing & ~bsda_r & ~sda_s)
									begin
										// another master pulled low while we sent a one
										bst_r <= S_IDLE;
										si_r <= 1'b1;
										stat_r <= `TW_ST_ARB;
									end
									else
										shift_r <= {shift_r[6:0], sda_s};
								default:
								begin
									bscl_r <= 1'b1;
									if (bcnt_r == 4'h8)
									begin
										si_r <= 1'b1;
										bst_r <= S_WAIT;
										adr_ph_r <= 1'b0;
										if (adr_ph_r)
										begin
											tx_r <= ~shift_r[0];
											if (shift_r[0])
												stat_r <= ack_r ? `TW_ST_MR_AACK : `TW_ST_MR_ANACK;
											else
												stat_r <= ack_r ? `TW_ST_MT_AACK : `TW_ST_MT_ANACK;
										end
										else if (tx_r)
											stat_r <= ack_r ? `TW_ST_MT_DACK : `TW_ST_MT_DNACK;
										else
											stat_r <= aa_r ? `TW_ST_MR_DACK : `TW_ST_MR_DNACK;
									end
									else
										bcnt_r <= bcnt_r + 4'h1;
								end
							endcase
						end
					S_WAIT:
					begin
						// clock held low while software owns the byte
						bscl_r <= 1'b1;
						qcnt_r <= 13'h0;
						ph_r <= 2'h0;
						bcnt_r <= 4'h0;
						if (!si_r)
						begin
							if (master_r)
							begin
								if (sto_r)
									bst_r <= S_MSTOP;
								else if (sta_r)
								begin
									bst_r <= S_MSTART;
									rs_r <= 1'b1;
								end
								else
									bst_r <= S_MBIT;
							end
							else
							begin
								bst_r <= S_SBIT;
								bscl_r <= 1'b0;
								bsda_r <= tx_r & ~shift_r[7];
							end
						end
					end
					S_MSTOP:
						if (tick)
						begin
							ph_r <= ph_r + 2'h1;
							case (ph_r)
								2'h0: bsda_r <= 1'b1;
								2'h1: bscl_r <= 1'b0;
								2'h2: bsda_r <= 1'b0;
								default:
								begin
									sto_r <= 1'b0;
									sta_r <= 1'b0;
									stat_r <= `TW_ST_IDLE;
									bst_r <= S_IDLE;
								end
							endcase
						end
					S_SBIT:
						if (bus_stop)
						begin
							bst_r <= S_IDLE;
							bsda_r <= 1'b0;
							stat_r <= `TW_ST_IDLE;
							if (~adr_ph_r & ~tx_r)
							begin
								si_r <= 1'b1;
								stat_r <= `TW_ST_SR_STOP;
							end
						end
						else if (bus_start)
						begin
							adr_ph_r <= 1'b1;
							tx_r <= 1'b0;
							bcnt_r <= 4'h0;
							bsda_r <= 1'b0;
						end
						else if (scl_rise)
						begin
							if (bcnt_r == 4'h8)
								ack_r <= ~sda_s;
							else
								shift_r <= {shift_r[6:0], sda_s};
						end
						else if (scl_fall)
						begin
							if (bcnt_r == 4'h7)
							begin
								bcnt_r <= 4'h8;
								if (adr_ph_r)
								begin
									if ((own_hit | gc_hit) & aa_r)
									begin
										bsda_r <= 1'b1;
										tx_r <= shift_r[0] & ~gc_hit;
									end
									else
										bst_r <= S_IDLE;
								end
								else
									bsda_r <= ~tx_r & aa_r;
							end
							else if (bcnt_r == 4'h8)
							begin
								si_r <= 1'b1;
								bscl_r <= 1'b1;
								bsda_r <= 1'b0;
								bst_r <= S_WAIT;
								adr_ph_r <= 1'b0;
								if (adr_ph_r)
									stat_r <= tx_r ? `TW_ST_ST_AACK :
										(gc_hit ? `TW_ST_SR_GACK : `TW_ST_SR_AACK);
								else if (tx_r)
									stat_r <= ack_r ? `TW_ST_ST_DACK : `TW_ST_ST_DNACK;
								else
									stat_r <= aa_r ? `TW_ST_SR_DACK : `TW_ST_SR_DNACK;
							end
							else
							begin
								bcnt_r <= bcnt_r + 4'h1;
								bsda_r <= tx_r & ~shift_r[7];
							end
						end
					default:
						bst_r <= S_IDLE;
				endcase
			end
		end
	end

	// bit engine; flags set by the bus win over a software clear in the same cycle
	wire stretch = str_r & ens_r & (rbf_r | wbf_r);
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			sdo_r <= 1'b1;
			sco_r <= 1'b1;
			clh_r <= 1'b0;
			str_r <= 1'b0;
			ens_r <= 1'b0;
			bb_r <= 1'b0;
			rbf_r <= 1'b0;
			wbf_r <= 1'b0;
			bsi_r <= 1'b0;
			wr_pend_r <= 1'b0;
		end
		else
		begin
			if (bus_start)
				bb_r <= 1'b1;
			else if (bus_stop)
				bb_r <= 1'b0;
			if (wr_scs)
			begin
				sdo_r <= wb[`TW_BS_SDA];
				sco_r <= wb[`TW_BS_SCL];
				str_r <= wb[`TW_BS_STR];
				ens_r <= wb[`TW_BS_ENS];
			end
			if (ens_r & scl_rise)
				clh_r <= 1'b1;
			else if (wr_scs)
				clh_r <= wb[`TW_BS_CLH];
			if (wr_sint & ~wb[0])
				bsi_r <= 1'b0;
			if (rd_sbd | wr_sbd)
			begin
				rbf_r <= 1'b0;
				wbf_r <= 1'b0;
			end
			if (ens_r & scl_fall)
			begin
				wr_pend_r <= 1'b0;
				bsi_r <= 1'b1;
				if (wr_pend_r)
					wbf_r <= 1'b1;
				else
					rbf_r <= 1'b1;
			end
			if (wr_sbd)
			begin
				sdo_r <= wb[0];
				wr_pend_r <= 1'b1;
			end
		end
	end

	// register file, interrupt status and pin drivers
	reg byte_ie_r;
	reg bit_ie_r;
	reg master_ie_r;
	reg [1:0] evt_r;
	reg si_q_r;
	reg bsi_q_r;
	reg [7:0] rd_val;
	reg hit;
	wire [1:0] evt_set = {bsi_r & ~bsi_q_r, si_r & ~si_q_r};

	always @*
	begin
		hit = 1'b1;
		rd_val = 8'h00;
		case (paddr)
			`TW_OFF_OWN: rd_val = own_addr_r;
			`TW_OFF_CTL:
				if (sel_r)
					rd_val = {cr_r[2], byte_engine_enable_r, sta_r, sto_r, si_r, aa_r, cr_r[1:0]};
				else
					rd_val = {sda_s, scl_s, clh_r, bb_r, rbf_r, wbf_r, str_r, ens_r};
			`TW_OFF_DAT: rd_val = sel_r ? shift_r : {7'h00, sda_s};
			`TW_OFF_STA: rd_val = sel_r ? {stat_r, 3'h0} : {7'h00, bsi_r};
			`TW_OFF_SEL: rd_val = {7'h00, sel_r};
			`TW_OFF_IE: rd_val = {master_ie_r, 5'h00, bit_ie_r, byte_ie_r};
			`TW_OFF_EVT: rd_val = {6'h00, evt_r};
			default: hit = 1'b0;
		endcase
	end

	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			own_addr_r <= 8'h00;
			sel_r <= 1'b0;
			byte_ie_r <= 1'b0;
			bit_ie_r <= 1'b0;
			master_ie_r <= 1'b0;
			evt_r <= 2'h0;
			si_q_r <= 1'b0;
			bsi_q_r <= 1'b0;
			irq <= 1'b0;
			sda_o <= 1'b0;
			sda_oe_n <= 1'b1;
			scl_o <= 1'b0;
			scl_oe_n <= 1'b1;
		end
		else
		begin
			pready <= acc & ~pready;
			pslverr <= acc & ~pready & ~hit;
			if (acc & ~pready)
				prdata <= pwrite ? 32'h0000_0000 : {24'h000000, rd_val};
			if (wr_own)
				own_addr_r <= wb;
			if (wr_en & (paddr == `TW_OFF_SEL))
				sel_r <= wb[0];
			if (wr_en & (paddr == `TW_OFF_IE))
			begin
				master_ie_r <= wb[`TW_IE_MASTER];
				bit_ie_r <= wb[`TW_IE_BIT];
				byte_ie_r <= wb[`TW_IE_BYTE];
			end
			si_q_r <= si_r;
			bsi_q_r <= bsi_r;
			if (wr_en & (paddr == `TW_OFF_EVT))
				evt_r <= (evt_r & ~wb[1:0]) | evt_set;
			else
				evt_r <= evt_r | evt_set;
			irq <= master_ie_r & |(evt_r & {bit_ie_r, byte_ie_r});
			sda_o <= 1'b0;
			scl_o <= 1'b0;
			// only the selected engine, and only when enabled, may pull a line
			if (sel_r)
			begin
				sda_oe_n <= ~(byte_engine_enable_r & bsda_r);
				scl_oe_n <= ~(byte_engine_enable_r & bscl_r);
			end
			else
			begin
				sda_oe_n <= ~(ens_r & ~sdo_r);
				scl_oe_n <= ~(ens_r & (~sco_r | stretch));
			end
		end
	end
endmodule // tw_port
`default_nettype wire

// ### bench/tw_port_properties.sv
// assertion checker for the two-wire port register bus and pins
`timescale 1ns/10ps
`default_nettype none
module tw_port_checker #(
	parameter [12:0] QUARTER_BASE = 13'h0020
)(
	input wire ref_clk,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire sda_o,
	input wire sda_oe_n,
	input wire scl_o,
	input wire scl_oe_n,
	input wire irq
);
	logic master_r;
	logic sel_r;
	logic ens_r;
	wire done_w = psel && penable && pready && pwrite && !pslverr;
	wire off_w = !sel_r && !ens_r;
	// shadow of the enables, updated at the edge a write takes effect
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			master_r <= 1'b0;
			sel_r <= 1'b0;
			ens_r <= 1'b0;
		end
		else if (done_w)
		begin
			if (paddr == 8'h14) master_r <= pwdata[7];
			if (paddr == 8'h10) sel_r <= pwdata[0];
			if (paddr == 8'h04 && !sel_r) ens_r <= pwdata[0];
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence wait_s;
		psel && penable && !pready;
	endsequence
	wait_state_a: assert property (setup_s ##1 wait_s |=> pready)
		else $error("pready not after one wait state");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	err_unmapped_a: assert property (pready && paddr > 8'h18 |-> pslverr)
		else $error("unmapped access not refused");
	err_mapped_a: assert property (pready && paddr <= 8'h18 && paddr[1:0] == 2'b00 |-> !pslverr)
		else $error("mapped access refused");
	rdata_upper_a: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	open_drain_a: assert property (!sda_o && !scl_o)
		else $error("pin output level not low");
	irq_master_a: assert property (!master_r && !$past(master_r) |-> !irq)
		else $error("interrupt with master enable off");
	pins_released_a: assert property (off_w && $past(off_w, 2) |-> sda_oe_n && scl_oe_n)
		else $error("pins driven with port disabled");
endmodule // tw_port_checker
bind tw_port tw_port_checker #(.QUARTER_BASE(QUARTER_BASE)) tw_port_checker_inst (
	.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.sda_o(sda_o), .sda_oe_n(sda_oe_n), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .irq(irq));
`default_nettype wire

// ### bench/tw_bus_partner.sv
// far side of the two-wire bus: pull-ups and a clocking peer
`timescale 1ns/10ps
`default_nettype none
module tw_bus_partner (
	input wire logic sda_oe_n,
	input wire logic scl_oe_n,
	input wire logic run,
	output wire logic sda,
	output wire logic scl
);
	logic lk = 1'b1;
	// peer clock stands high between frames
	always #62.5 lk = run ? ~lk : 1'b1;
	// wired-and with pull-ups; the peer never pulls data low here
	assign sda = sda_oe_n;
	assign scl = scl_oe_n & lk;
endmodule // tw_bus_partner
`default_nettype wire

// ### bench/tw_port_test.sv
// self-checking testbench of the two-wire port
`timescale 1ns/10ps
`default_nettype none
`include "tw_port_consts.vh"
module tw_port_test;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [7:0] rv;
	logic ev;
	wire [31:0] prdata;
	wire pready, pslverr, sda_o, sda_oe_n, scl_o, scl_oe_n, irq, sda, scl;
	integer miscompares = 0, cmp_count = 0;
	always #4 ref_clk = ~ref_clk;
	tw_port #(.QUARTER_BASE(13'h0004)) tw_port_inst (.ref_clk(ref_clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sda_i(sda), .sda_o(sda_o),
		.sda_oe_n(sda_oe_n), .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .irq(irq));
	tw_bus_partner tw_bus_partner_inst (.sda_oe_n(sda_oe_n), .scl_oe_n(scl_oe_n),
		.run(run), .sda(sda), .scl(scl));
	task test_done;
	begin
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end
	endtask
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
	begin
		cmp_count = cmp_count + 1;
		if (got !== exp)
		begin
			miscompares = miscompares + 1;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	end
	endtask
	// one transfer, then one idle cycle so back-to-back calls never clash
	task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		integer n;
	begin
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		@(posedge ref_clk);
		while (pready !== 1'b1 && n < 20)
		begin
			n = n + 1;
			@(posedge ref_clk);
		end
		if (n >= 20)
		begin
			miscompares = miscompares + 1;
			test_done;
		end
		rv = prdata[7:0];
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	end
	endtask
	task rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
	begin
		apb(1'b0, a, 8'h00);
		chk(what, exp, rv);
	end
	endtask
	initial
	begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		apb(1'b1, `TW_OFF_SEL, 8'h01);
		rdc("status", `TW_OFF_STA, 8'hf8);
		apb(1'b1, `TW_OFF_STA, 8'h00);
		rdc("status", `TW_OFF_STA, 8'hf8);
		apb(1'b1, `TW_OFF_OWN, 8'ha5);
		rdc("own address", `TW_OFF_OWN, 8'ha5);
		apb(1'b1, `TW_OFF_DAT, 8'h5a);
		rdc("byte data", `TW_OFF_DAT, 8'h5a);
		apb(1'b0, 8'h1c, 8'h00);
		chk("slverr", 8'h01, {7'h0, ev});
		apb(1'b1, `TW_OFF_SEL, 8'h00);
		apb(1'b1, `TW_OFF_IE, 8'h82);
		apb(1'b1, `TW_OFF_CTL, 8'hc3);
		run <= 1'b1;
		repeat (10) @(posedge ref_clk);
		run <= 1'b0;
		repeat (20) @(posedge ref_clk);
		chk("scl_oe_n", 8'h00, {7'h0, scl_oe_n});
		chk("irq", 8'h01, {7'h0, irq});
		rdc("bit flag", `TW_OFF_STA, 8'h01);
		rdc("bit control", `TW_OFF_CTL, 8'h8b);
		apb(1'b1, `TW_OFF_IE, 8'h02);
		repeat (3) @(posedge ref_clk);
		chk("irq", 8'h00, {7'h0, irq});
		apb(1'b1, `TW_OFF_IE, 8'h82);
		repeat (3) @(posedge ref_clk);
		chk("irq", 8'h01, {7'h0, irq});
		rdc("bit data", `TW_OFF_DAT, 8'h01);
		repeat (10) @(posedge ref_clk);
		chk("scl_oe_n", 8'h01, {7'h0, scl_oe_n});
		rdc("bit control", `TW_OFF_CTL, 8'he3);
		apb(1'b1, `TW_OFF_CTL, 8'h43);
		repeat (4) @(posedge ref_clk);
		chk("sda_oe_n", 8'h00, {7'h0, sda_oe_n});
		rdc("bit control", `TW_OFF_CTL, 8'h53);
		apb(1'b1, `TW_OFF_DAT, 8'h01);
		repeat (4) @(posedge ref_clk);
		chk("sda_oe_n", 8'h01, {7'h0, sda_oe_n});
		apb(1'b1, `TW_OFF_STA, 8'h00);
		apb(1'b1, `TW_OFF_EVT, 8'h02);
		repeat (3) @(posedge ref_clk);
		chk("irq", 8'h00, {7'h0, irq});
		apb(1'b1, `TW_OFF_CTL, 8'h40);
		repeat (4) @(posedge ref_clk);
		chk("sda_oe_n", 8'h01, {7'h0, sda_oe_n});
		apb(1'b1, `TW_OFF_IE, 8'h81);
		apb(1'b1, `TW_OFF_SEL, 8'h01);
		apb(1'b1, `TW_OFF_CTL, 8'h60);
		repeat (2000)
		begin
			if (irq !== 1'b1)
				@(posedge ref_clk);
		end
		chk("irq", 8'h01, {7'h0, irq});
		rdc("status", `TW_OFF_STA, 8'h08);
		rdc("event", `TW_OFF_EVT, 8'h01);
		// stop request with si cleared ends the frame and returns the code to idle
		apb(1'b1, `TW_OFF_CTL, 8'h50);
		repeat (60) @(posedge ref_clk);
		rdc("status", `TW_OFF_STA, 8'hf8);
		rdc("byte control", `TW_OFF_CTL, 8'h40);
		test_done;
	end
endmodule // tw_port_test
`default_nettype wire
